/* File: verification/spd_mem_model.sv */
// Purpose: Local memory slave on the DMA bus port
// Assumes: Word array indexed by the low address byte
// Notes:   slow adds three wait cycles; idle read data toggles
`timescale 1ns/1ps
`default_nettype none
module spd_mem_model (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  slow,
    input  wire logic                  busReq,
    input  wire spd_pkg::spd_bus_req_s busCmd,
    output logic                       busAck,
    output logic [31:0]                busRdata
);
    logic [31:0] mem [256];
    logic [1:0]  waitCnt;
    always @(posedge clk)
    begin
        busAck <= 1'b0;
        busRdata <= ~busRdata;
        if (rst)
        begin
            waitCnt <= 2'h0;
            busRdata <= 32'h0;
        end
        else if (busReq && !busAck)
        begin
            waitCnt <= waitCnt + 2'h1;
            if (!slow || waitCnt == 2'h3)
            begin
                busAck <= 1'b1;
                busRdata <= mem[busCmd.addr[7:0]];
                if (busCmd.write)
                    mem[busCmd.addr[7:0]] <= busCmd.wdata;
            end
        end
    end
endmodule : spd_mem_model
`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for the DMA channel block
// Assumes: Memory model answers the bus port
// Notes:   Random data from an xorshift seeded at 71
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic            clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, slow = 1'b0;
    logic [11:0]     regAddr = 12'h000;
    logic [31:0]     regWdata = 32'h0, regRdata, busRdata, v, seed = 32'h47;
    logic [7:0]      dmaReq = 8'h00, eopIn = 8'h00, serTxData, rxb;
    logic [7:0][7:0] serRxData = 64'h0;
    logic [3:0]      portIrq;
    logic            busReq, busAck;
    spd_pkg::spd_bus_req_s busCmd;
    int              err_count = 0, samples_checked = 0;
    always #20 clk = ~clk;
    spd_dma_channels u_spd_dma_channels (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .dmaReq(dmaReq), .eopIn(eopIn), .serRxData(serRxData), .dmaAck(),
        .serTxData(serTxData), .busReq(busReq), .busCmd(busCmd), .busAck(busAck),
        .busRdata(busRdata), .portIrq(portIrq));
    spd_mem_model u_spd_mem_model (.clk(clk), .rst(rst), .slow(slow), .busReq(busReq),
        .busCmd(busCmd), .busAck(busAck), .busRdata(busRdata));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [11:0] ra(input int ch, input logic [4:0] off);
        return 12'(ch * 32) | {7'h00, off};
    endfunction : ra
    function automatic logic [31:0] cw(input logic [15:0] n);
        return {spd_pkg::QUEUE_OFF, n};
    endfunction : cw
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(posedge clk);
        v = regRdata;
    endtask : rd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        rd(a);
        chk(v, exp);
    endtask : rchk
    task automatic complete_run();
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    task automatic wait_stop(input int ch);
        for (int n = 0; n < 300; n++)
        begin
            rd(ra(ch, spd_pkg::OFF_CMD));
            if (v[0] === 1'b0)
                return;
        end
        chk({31'h0, v[0]}, 32'h0);
        complete_run();
    endtask : wait_stop
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (int i = 0; i < 256; i++)
            u_spd_mem_model.mem[i] = rnd();
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rchk(ra(0, spd_pkg::OFF_CNT), cw(spd_pkg::CNT_ZERO));
        wr(12'h100, 32'h0000_000F);
        wr(ra(0, spd_pkg::OFF_MEM), 32'h0000_0010);
        wr(ra(0, spd_pkg::OFF_CHN), spd_pkg::WORD_ZERO);
        wr(ra(0, spd_pkg::OFF_CNT), cw(16'h0003));
        wr(ra(0, spd_pkg::OFF_CMD), 32'h0000_2403);
        rchk(ra(0, spd_pkg::OFF_CMD), 32'h0000_2403);
        dmaReq <= 8'h01;
        wait_stop(0);
        dmaReq <= 8'h00;
        rchk(ra(0, spd_pkg::OFF_CNT), cw(spd_pkg::CNT_ZERO));
        rchk(ra(0, spd_pkg::OFF_MEM), 32'h0000_0013);
        chk({24'h0, serTxData}, {24'h0, u_spd_mem_model.mem[18][7:0]});
        chk({28'h0, portIrq}, 32'h1);
        wr(12'h104, 32'h0000_0001);
        rchk(12'h104, 32'h0);
        chk({28'h0, portIrq}, 32'h0);
        // Receive side, slow memory, end of packet on first byte
        rxb = 8'(rnd());
        serRxData <= {8{rxb}};
        slow <= 1'b1;
        eopIn <= 8'h02;
        wr(ra(1, spd_pkg::OFF_MEM), 32'h0000_0040);
        wr(ra(1, spd_pkg::OFF_CNT), cw(16'h0028));
        wr(ra(1, spd_pkg::OFF_CMD), 32'h0000_4811);
        dmaReq <= 8'h02;
        wait_stop(1);
        dmaReq <= 8'h00;
        rchk(ra(1, spd_pkg::OFF_CNT), cw(16'h0027));
        chk({24'h0, u_spd_mem_model.mem[64][7:0]}, {24'h0, rxb});
        chk({28'h0, portIrq}, 32'h1);
        u_spd_mem_model.mem[128] = 32'h2402;
        u_spd_mem_model.mem[132] = cw(16'h1);
        u_spd_mem_model.mem[136] = 32'h50;
        u_spd_mem_model.mem[140] = 32'h0;
        wr(ra(2, spd_pkg::OFF_MEM), 32'h20);
        wr(ra(2, spd_pkg::OFF_AIO), 32'h30);
        wr(ra(2, spd_pkg::OFF_CHN), 32'h80);
        wr(ra(2, spd_pkg::OFF_CNT), cw(16'h1));
        wr(ra(2, spd_pkg::OFF_CMD), 32'h000A_0083);
        dmaReq <= 8'h04;
        wait_stop(2);
        rchk(ra(2, spd_pkg::OFF_MEM), 32'h51);
        rchk(ra(2, spd_pkg::OFF_CMD), 32'h2402);
        // Run control on an idle channel
        wr(ra(3, spd_pkg::OFF_CMD), 32'h0000_2401);
        wr(ra(3, spd_pkg::OFF_RUN), spd_pkg::RUN_STOP);
        rchk(ra(3, spd_pkg::OFF_CMD), 32'h0000_2400);
        wr(ra(3, spd_pkg::OFF_RUN), spd_pkg::RUN_RESTART);
        rchk(ra(3, spd_pkg::OFF_CMD), 32'h0000_2401);
        wr(ra(3, spd_pkg::OFF_RUN), spd_pkg::RUN_RESET);
        rchk(ra(3, spd_pkg::OFF_CMD), 32'h0000_2400);
        wr(ra(3, spd_pkg::OFF_CMD), 32'h0000_2401);
        rchk(ra(3, spd_pkg::OFF_CMD), 32'h0000_2400);
        wr(ra(3, spd_pkg::OFF_RUN), spd_pkg::RUN_STOP);
        wr(ra(3, spd_pkg::OFF_CMD), 32'h0000_2401);
        rchk(ra(3, spd_pkg::OFF_CMD), 32'h0000_2401);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire

/* File: verilog/spd_dma_channels.sv */
// Purpose: DMA channels between local memory and the serial port transmit/receive sides
// Assumes: One shared bus master port; single-address byte transfers to the serial side
// Notes:   Even channels face port transmitters, odd channels port receivers
// Behaviour
// RQ1: Setting command bit 0 starts a channel; bit 0 reads 1 while running.
// RQ2: Run control write of 0 stops the channel; command bit 0 reads 0.
// RQ3: Run control write of 1 restarts a stopped channel; bit 0 reads 1.
// RQ4: Run control write of 2 enters reset state, halted, bit 0 reads 0.
// RQ5: Run control write of 0 takes a channel out of reset state.
// RQ6: Command 2402h/2400h stops and interrupts at terminal count.
// RQ7: Command A0082h chains at terminal count, appended read then write.
// RQ8: Command 60110h chains on end of packet, appended write then read.
// RQ9: Command 4810h stops a receive channel on end of packet.
// RQ10: Stop and interrupt on end of packet acts before count runs out.
// RQ11: Appended I/O cycles target the per-channel appended I/O address register.
// RQ12: Count word holds count low, queue control high; 00FF disables queuing.
// RQ13: Chain pointer addresses next descriptor block; zero means no chain.
// RQ14: Interrupt mask 0Fh enables interrupts of all four serial ports.
// RQ15: Each transfer advances the pointer, decrements count; zero is terminal count.
`timescale 1ns/1ps
`default_nettype none

module spd_dma_channels #(
    parameter int NCH   = spd_pkg::NCH_DEF,
    parameter int NPORT = spd_pkg::NCH_DEF / 2
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic [spd_pkg::ADDR_W-1:0]    regAddr,
    input  wire logic [31:0]                   regWdata,
    input  wire logic                          regWr,
    input  wire logic                          regRd,
    output logic      [31:0]                   regRdata,
    input  wire logic [NCH-1:0]                dmaReq,
    input  wire logic [NCH-1:0]                eopIn,
    input  wire logic [NCH-1:0][7:0]           serRxData,
    output logic      [NCH-1:0]                dmaAck,
    output logic      [7:0]                    serTxData,
    output logic                               busReq,
    output spd_pkg::spd_bus_req_s              busCmd,
    input  wire logic                          busAck,
    input  wire logic [31:0]                   busRdata,
    output logic      [NPORT-1:0]              portIrq
);

    localparam int CHW = spd_pkg::CH_W;

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [NCH-1:0][31:0]  cmdR;
    logic [NCH-1:0][31:0]  cntR;
    logic [NCH-1:0][31:0]  memR;
    logic [NCH-1:0][31:0]  chnR;
    logic [NCH-1:0][31:0]  aioR;
    logic [NCH-1:0]        resetSt_r;
    logic [NCH-1:0]        pend_r;
    logic [NPORT-1:0]      mask_r;
    spd_pkg::spd_state_e   state_r;
    logic [CHW-1:0]        chSel_r;
    logic [31:0]           data_r;
    logic [31:0]           descBase_r;
    logic [1:0]            loadIdx_r;
    logic                  tcF_r;
    logic                  stopF_r;
    logic                  chainF_r;
    logic                  intF_r;

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    logic [CHW-1:0]  wrCh;
    logic [4:0]      wrOff;
    logic            chanAcc;
    logic            swCmdWr;
    logic            swRunWr;
    logic [31:0]     cmdSel;
    logic [15:0]     cntSel;
    logic            xferDone;
    logic            tcNow;
    logic            eopNow;
    logic            stopNow;
    logic            chainNow;
    logic            intNow;
    logic            appNow;
    logic            doneStop;
    logic            doneChain;
    logic            loadAck;
    logic            pickValid;
    logic [CHW-1:0]  pickCh;

    assign wrCh     = regAddr[spd_pkg::CH_LSB +: CHW];
    assign wrOff    = regAddr[4:0];
    assign chanAcc  = !regAddr[spd_pkg::GLOBAL_BIT] && (32'(wrCh) < NCH);
    assign swCmdWr  = regWr && chanAcc && (wrOff == spd_pkg::OFF_CMD);
    assign swRunWr  = regWr && chanAcc && (wrOff == spd_pkg::OFF_RUN);
    assign cmdSel   = cmdR[chSel_r];
    assign cntSel   = cntR[chSel_r][spd_pkg::CNT_W-1:0];

    // Outcome of the transfer that completes this cycle
    assign xferDone = (state_r == spd_pkg::ST_XFER) && busAck;
    assign tcNow    = (cntSel == spd_pkg::CNT_ONE); // RQ15
    assign eopNow   = !cmdSel[spd_pkg::CMD_TX] && cmdSel[spd_pkg::CMD_EOP_EN] && eopIn[chSel_r];
    assign stopNow  = (tcNow && cmdSel[spd_pkg::CMD_STOP_TC])
                   || (eopNow && cmdSel[spd_pkg::CMD_STOP_EOP]); // RQ6 RQ9 RQ10
    assign chainNow = (tcNow && cmdSel[spd_pkg::CMD_CHAIN_TC])
                   || (eopNow && cmdSel[spd_pkg::CMD_CHAIN_EOP]); // RQ7 RQ8
    assign intNow   = (tcNow && cmdSel[spd_pkg::CMD_INT_TC])
                   || (eopNow && cmdSel[spd_pkg::CMD_INT_EOP]); // RQ6 RQ10
    assign appNow   = cmdSel[spd_pkg::CMD_APP_EN] && (tcNow || stopNow || chainNow);

    assign doneChain = (state_r == spd_pkg::ST_DONE) && chainF_r
                    && (chnR[chSel_r] != spd_pkg::WORD_ZERO); // RQ13
    assign doneStop  = (state_r == spd_pkg::ST_DONE) && !doneChain
                    && (tcF_r || stopF_r || chainF_r);
    assign loadAck   = (state_r == spd_pkg::ST_LOAD) && busAck;

    // Lowest numbered ready channel wins
    always_comb
    begin
        pickValid = 1'b0;
        pickCh    = '0;
        for (int i = NCH - 1; i >= 0; i--)
        begin
            if (cmdR[i][spd_pkg::CMD_RUN] && !resetSt_r[i] && dmaReq[i]
                && (cntR[i][spd_pkg::CNT_W-1:0] != spd_pkg::CNT_ZERO))
            begin
                pickValid = 1'b1;
                pickCh    = CHW'(i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel registers; software writes override engine updates
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cmdR      <= '0;
            cntR      <= {NCH{spd_pkg::QUEUE_OFF, spd_pkg::CNT_ZERO}};
            memR      <= '0;
            chnR      <= '0;
            aioR      <= '0;
            resetSt_r <= '0;
        end
        else
        begin
            if (xferDone)
            begin
                memR[chSel_r] <= memR[chSel_r] + spd_pkg::MEM_STEP; // RQ15
                cntR[chSel_r][spd_pkg::CNT_W-1:0] <= cntSel - spd_pkg::CNT_ONE; // RQ15 RQ12
            end
            if (doneStop)
                cmdR[chSel_r][spd_pkg::CMD_RUN] <= 1'b0; // RQ6 RQ9 RQ10 RQ13
            if (loadAck)
            begin
                case (loadIdx_r)
                    spd_pkg::DESC_FIRST:
                        cmdR[chSel_r] <= {busRdata[31:1], cmdSel[spd_pkg::CMD_RUN]}; // RQ7 RQ8
                    spd_pkg::DESC_CNT:
                        cntR[chSel_r] <= busRdata;
                    spd_pkg::DESC_MEM:
                        memR[chSel_r] <= busRdata;
                    default:
                        chnR[chSel_r] <= busRdata; // RQ13
                endcase
            end
            if (swCmdWr)
                cmdR[wrCh] <= {regWdata[31:1], regWdata[spd_pkg::CMD_RUN] && !resetSt_r[wrCh]}; // RQ1
            if (regWr && chanAcc && (wrOff == spd_pkg::OFF_CNT))
                cntR[wrCh] <= regWdata; // RQ12
            if (regWr && chanAcc && (wrOff == spd_pkg::OFF_MEM))
                memR[wrCh] <= regWdata;
            if (regWr && chanAcc && (wrOff == spd_pkg::OFF_CHN))
                chnR[wrCh] <= regWdata; // RQ13
            if (regWr && chanAcc && (wrOff == spd_pkg::OFF_AIO))
                aioR[wrCh] <= regWdata; // RQ11
            if (swRunWr)
            begin
                case (regWdata)
                    spd_pkg::RUN_STOP:
                    begin
                        cmdR[wrCh][spd_pkg::CMD_RUN] <= 1'b0; // RQ2
                        resetSt_r[wrCh]              <= 1'b0; // RQ5
                    end
                    spd_pkg::RUN_RESTART:
                    begin
                        if (!resetSt_r[wrCh])
                            cmdR[wrCh][spd_pkg::CMD_RUN] <= 1'b1; // RQ3
                    end
                    spd_pkg::RUN_RESET:
                    begin
                        cmdR[wrCh][spd_pkg::CMD_RUN] <= 1'b0; // RQ4
                        resetSt_r[wrCh]              <= 1'b1; // RQ4
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt pending and mask; a new event beats a clear
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pend_r <= '0;
            mask_r <= spd_pkg::MASK_RST;
        end
        else
        begin
            if (regWr && regAddr[spd_pkg::GLOBAL_BIT] && (wrOff == spd_pkg::OFF_MASK))
                mask_r <= regWdata[NPORT-1:0]; // RQ14
            pend_r <= (pend_r & ~((regWr && regAddr[spd_pkg::GLOBAL_BIT]
                                   && (wrOff == spd_pkg::OFF_PEND)) ? regWdata[NCH-1:0] : '0))
                    | (((state_r == spd_pkg::ST_DONE) && intF_r)
                       ? (NCH'(1) << chSel_r) : '0); // RQ6 RQ10
        end
    end

    always_comb
    begin
        for (int p = 0; p < NPORT; p++)
            portIrq[p] = mask_r[p] && (pend_r[2*p] || pend_r[2*p+1]); // RQ14
    end

    ////////////////////////////////////////////////////////////////////////////
    // Engine sequencer and bus master
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_r    <= spd_pkg::ST_IDLE;
            chSel_r    <= '0;
            busReq     <= 1'b0;
            busCmd     <= '0;
            data_r     <= '0;
            descBase_r <= '0;
            loadIdx_r  <= spd_pkg::DESC_FIRST;
            tcF_r      <= 1'b0;
            stopF_r    <= 1'b0;
            chainF_r   <= 1'b0;
            intF_r     <= 1'b0;
            dmaAck     <= '0;
            serTxData  <= '0;
        end
        else
        begin
            dmaAck <= '0;
            case (state_r)
                spd_pkg::ST_IDLE:
                begin
                    if (pickValid)
                    begin
                        chSel_r      <= pickCh;
                        busReq       <= 1'b1;
                        busCmd.io    <= 1'b0;
                        busCmd.write <= !cmdR[pickCh][spd_pkg::CMD_TX];
                        busCmd.addr  <= memR[pickCh];
                        busCmd.wdata <= {24'h00_0000, serRxData[pickCh]};
                        state_r      <= spd_pkg::ST_XFER;
                    end
                end
                spd_pkg::ST_XFER:
                begin
                    if (busAck)
                    begin
                        busReq          <= 1'b0;
                        dmaAck[chSel_r] <= 1'b1;
                        tcF_r           <= tcNow;
                        stopF_r         <= stopNow;
                        chainF_r        <= chainNow;
                        intF_r          <= intNow;
                        if (cmdSel[spd_pkg::CMD_TX])
                        begin
                            data_r    <= busRdata;
                            serTxData <= busRdata[7:0];
                        end
                        else
                            data_r <= busCmd.wdata;
                        if (appNow)
                        begin
                            busReq       <= 1'b1;
                            busCmd.io    <= 1'b1; // RQ11
                            busCmd.addr  <= aioR[chSel_r]; // RQ11
                            busCmd.write <= !cmdSel[spd_pkg::CMD_RD_FIRST]; // RQ7 RQ8
                            busCmd.wdata <= cmdSel[spd_pkg::CMD_TX] ? busRdata : busCmd.wdata;
                            state_r      <= spd_pkg::ST_APP1;
                        end
                        else
                            state_r <= spd_pkg::ST_DONE;
                    end
                end
                spd_pkg::ST_APP1:
                begin
                    if (busAck)
                    begin
                        if (!busCmd.write)
                            data_r <= busRdata;
                        busCmd.write <= !busCmd.write; // RQ7 RQ8
                        busCmd.wdata <= busCmd.write ? data_r : busRdata;
                        state_r      <= spd_pkg::ST_APP2;
                    end
                end
                spd_pkg::ST_APP2:
                begin
                    if (busAck)
                    begin
                        if (!busCmd.write)
                            data_r <= busRdata;
                        busReq  <= 1'b0;
                        state_r <= spd_pkg::ST_DONE;
                    end
                end
                spd_pkg::ST_DONE:
                begin
                    if (doneChain)
                    begin
                        descBase_r   <= chnR[chSel_r];
                        loadIdx_r    <= spd_pkg::DESC_FIRST;
                        busReq       <= 1'b1;
                        busCmd.io    <= 1'b0;
                        busCmd.write <= 1'b0;
                        busCmd.addr  <= chnR[chSel_r]; // RQ13
                        state_r      <= spd_pkg::ST_LOAD;
                    end
                    else
                        state_r <= spd_pkg::ST_IDLE;
                end
                spd_pkg::ST_LOAD:
                begin
                    if (busAck)
                    begin
                        if (loadIdx_r == spd_pkg::DESC_LAST)
                        begin
                            busReq  <= 1'b0;
                            state_r <= spd_pkg::ST_IDLE;
                        end
                        else
                        begin
                            loadIdx_r   <= loadIdx_r + 2'h1;
                            busCmd.addr <= busCmd.addr + spd_pkg::DESC_STEP;
                        end
                    end
                end
                default:
                begin
                    busReq  <= 1'b0;
                    state_r <= spd_pkg::ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read port
    always_ff @(posedge clk)
    begin
        if (rst)
            regRdata <= '0;
        else if (regRd)
        begin
            regRdata <= '0;
            if (regAddr[spd_pkg::GLOBAL_BIT])
            begin
                if (wrOff == spd_pkg::OFF_MASK)
                    regRdata <= 32'(mask_r);
                else if (wrOff == spd_pkg::OFF_PEND)
                    regRdata <= 32'(pend_r);
            end
            else if (chanAcc)
            begin
                case (wrOff)
                    spd_pkg::OFF_CMD: regRdata <= cmdR[wrCh]; // RQ1
                    spd_pkg::OFF_CNT: regRdata <= cntR[wrCh];
                    spd_pkg::OFF_MEM: regRdata <= memR[wrCh];
                    spd_pkg::OFF_CHN: regRdata <= chnR[wrCh];
                    spd_pkg::OFF_AIO: regRdata <= aioR[wrCh];
                    spd_pkg::OFF_RUN: regRdata <= 32'(resetSt_r[wrCh]);
                    default:          regRdata <= '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    AST_START: assert property (@(posedge clk) disable iff (rst) // RQ1
        swCmdWr && regWdata[spd_pkg::CMD_RUN] && !resetSt_r[wrCh] && !swRunWr
        |=> cmdR[$past(wrCh)][spd_pkg::CMD_RUN])
        else $error("start bit did not read back set");
    AST_STOP: assert property (@(posedge clk) disable iff (rst) // RQ2
        swRunWr && (regWdata == spd_pkg::RUN_STOP)
        |=> !cmdR[$past(wrCh)][spd_pkg::CMD_RUN])
        else $error("stop did not clear run bit");
    AST_RESTART: assert property (@(posedge clk) disable iff (rst) // RQ3
        swRunWr && (regWdata == spd_pkg::RUN_RESTART) && !resetSt_r[wrCh]
        |=> cmdR[$past(wrCh)][spd_pkg::CMD_RUN])
        else $error("restart did not set run bit");
    AST_RESET: assert property (@(posedge clk) disable iff (rst) // RQ4
        swRunWr && (regWdata == spd_pkg::RUN_RESET)
        |=> resetSt_r[$past(wrCh)] && !cmdR[$past(wrCh)][spd_pkg::CMD_RUN])
        else $error("reset state not entered");
    AST_UNRESET: assert property (@(posedge clk) disable iff (rst) // RQ5
        swRunWr && (regWdata == spd_pkg::RUN_STOP) |=> !resetSt_r[$past(wrCh)])
        else $error("reset state not left");
    AST_TC_STOP: assert property (@(posedge clk) disable iff (rst) // RQ6
        xferDone && tcNow && cmdSel[spd_pkg::CMD_STOP_TC] && cmdSel[spd_pkg::CMD_INT_TC]
        && !appNow && !regWr
        |-> ##2 pend_r[chSel_r] && !cmdR[chSel_r][spd_pkg::CMD_RUN])
        else $error("no stop and interrupt at terminal count");
    AST_EOP_STOP: assert property (@(posedge clk) disable iff (rst) // RQ9 RQ10
        xferDone && eopNow && cmdSel[spd_pkg::CMD_STOP_EOP] && !appNow && !regWr
        |-> ##2 !cmdR[chSel_r][spd_pkg::CMD_RUN])
        else $error("no stop on end of packet");
    AST_APP_ORDER: assert property (@(posedge clk) disable iff (rst) // RQ7 RQ8 RQ11
        (state_r == spd_pkg::ST_APP1) && busReq
        |-> busCmd.io && (busCmd.addr == aioR[chSel_r])
            && (busCmd.write == !cmdSel[spd_pkg::CMD_RD_FIRST]))
        else $error("appended cycle wrong address or order");
    AST_CHAIN: assert property (@(posedge clk) disable iff (rst) // RQ13
        doneChain |=> (state_r == spd_pkg::ST_LOAD) && busReq && !busCmd.write
                      && (busCmd.addr == descBase_r))
        else $error("chain load not started");
    AST_COUNT: assert property (@(posedge clk) disable iff (rst) // RQ15 RQ12
        xferDone && !regWr
        |=> (cntR[$past(chSel_r)][spd_pkg::CNT_W-1:0] == $past(cntSel) - spd_pkg::CNT_ONE)
            && (cntR[$past(chSel_r)][31:16] == $past(cntR[chSel_r][31:16]))
            && (memR[$past(chSel_r)] == $past(memR[chSel_r]) + spd_pkg::MEM_STEP))
        else $error("count or pointer not advanced");
    AST_MASK: assert property (@(posedge clk) disable iff (rst) // RQ14
        (mask_r == {NPORT{1'b1}}) && (pend_r != '0) |-> (portIrq != '0))
        else $error("enabled interrupt not raised");

endmodule : spd_dma_channels

`default_nettype wire

/* File: verilog/spd_pkg.sv */
// Purpose: Shared constants and types for the serial port DMA channel block
// Assumes: 32-bit register words, byte-wide serial transfers
// Notes:   Channel registers sit in blocks of 0x20 bytes, global registers above
package spd_pkg;

    localparam int NCH_DEF    = 8;
    localparam int ADDR_W     = 12;
    localparam int CH_LSB     = 5;
    localparam int CH_W       = 3;
    localparam int GLOBAL_BIT = 8;
    localparam int CNT_W      = 16;

    // Per-channel register offsets inside a channel block
    localparam logic [4:0] OFF_CMD  = 5'h00;
    localparam logic [4:0] OFF_CNT  = 5'h04;
    localparam logic [4:0] OFF_MEM  = 5'h08;
    localparam logic [4:0] OFF_CHN  = 5'h0C;
    localparam logic [4:0] OFF_AIO  = 5'h10;
    localparam logic [4:0] OFF_RUN  = 5'h14;
    // Global register offsets
    localparam logic [4:0] OFF_MASK = 5'h00;
    localparam logic [4:0] OFF_PEND = 5'h04;

    // Channel command word fields
    localparam int CMD_RUN       = 0;
    localparam int CMD_TX        = 1;
    localparam int CMD_EOP_EN    = 4;
    localparam int CMD_CHAIN_TC  = 7;
    localparam int CMD_CHAIN_EOP = 8;
    localparam int CMD_STOP_TC   = 10;
    localparam int CMD_STOP_EOP  = 11;
    localparam int CMD_INT_TC    = 13;
    localparam int CMD_INT_EOP   = 14;
    localparam int CMD_APP_EN    = 17;
    localparam int CMD_WR_FIRST  = 18;
    localparam int CMD_RD_FIRST  = 19;

    // Per-channel run control codes
    localparam logic [31:0] RUN_STOP    = 32'h0000_0000;
    localparam logic [31:0] RUN_RESTART = 32'h0000_0001;
    localparam logic [31:0] RUN_RESET   = 32'h0000_0002;

    localparam logic [15:0] QUEUE_OFF   = 16'h00FF;
    localparam logic [15:0] CNT_ONE     = 16'h0001;
    localparam logic [15:0] CNT_ZERO    = 16'h0000;
    localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
    localparam logic [31:0] MEM_STEP    = 32'h0000_0001;
    localparam logic [31:0] DESC_STEP   = 32'h0000_0004;
    localparam logic [1:0]  DESC_FIRST  = 2'h0;
    localparam logic [1:0]  DESC_CNT    = 2'h1;
    localparam logic [1:0]  DESC_MEM    = 2'h2;
    localparam logic [1:0]  DESC_LAST   = 2'h3;
    localparam logic [3:0]  MASK_RST    = 4'h0;

    typedef struct packed {
        logic        io;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } spd_bus_req_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_XFER = 3'b001,
        ST_APP1 = 3'b010,
        ST_APP2 = 3'b011,
        ST_DONE = 3'b100,
        ST_LOAD = 3'b101
    } spd_state_e;

endpackage : spd_pkg
